// file: rtl/power_mode_pkg.sv
// Functional notes
// [RULE_01] Master clear, software, power-on, brown-out and watchdog resets merge into system reset.
// [RULE_02] Power-up hold keeps extending while brown-out reset stays active.
// [RULE_03] Fast oscillator runs at 40 MHz for transmit, converter trigger and processor.
// [RULE_04] Fast oscillator clock is stopped throughout deep sleep.
// [RULE_05] Slow 32 kHz oscillator always runs and times the power-saving modes.
// [RULE_06] Power-saving behaviour comes from host configuration, not fixed hardware settings.
// [RULE_07] Processing entered on bus access, approach or resets; left on message or timeout.
// [RULE_08] Approach mode entered on timeout or message; left on message, resets or hand.
// [RULE_09] Approach mode wakes periodically from a wake-up timer for scan phases.
// [RULE_10] Deep sleep entered by message only; left by bus or master clear; watchdog off.
// [RULE_11] Host must trigger the exit from deep sleep; device detects nothing there.
// [RULE_12] Processing mode enables all domains, runs the processor, keeps peripherals active.
// [RULE_13] Gesture recognition and position tracking are offered only in processing mode.
// [RULE_14] Deep sleep keeps host pins active and wakes on a bus start condition.
// [RULE_15] Wake-up timer is programmable and counts on the slow oscillator.
// [RULE_16] Inactivity counter restarts on user presence and requests approach mode on expiry.
// [RULE_17] After system reset release the controller starts in processing, both oscillators on.
package power_mode_pkg;

    // ************************************************************
    // Modes and carriers
    // ************************************************************
    typedef enum logic [1:0] {
        MODE_PROCESSING = 2'b00,
        MODE_APPROACH   = 2'b01,
        MODE_DEEP_SLEEP = 2'b10
    } power_mode_t;

    typedef struct packed {
        logic        valid;
        power_mode_t mode;
    } host_mode_req_t;

    typedef struct packed {
        logic fast_osc_en;
        logic slow_osc_en;
        logic signal_processor_run;
        logic watchdog_en;
        logic peripherals_active;
        logic all_domains_en;
        logic gesture_tracking_en;
        logic host_pins_active;
    } domain_ctrl_t;

    // ************************************************************
    // Clocks and timing
    // ************************************************************
    localparam int unsigned CLOCK_HZ        = 25_000_000;
    localparam int unsigned FAST_OSC_HZ     = 40_000_000;
    localparam int unsigned SLOW_OSC_HZ     = 32_000;
    // Slow tick period, rounded down so the tick never runs slower than nominal
    localparam int unsigned SLOW_TICK_CYCLES = CLOCK_HZ / SLOW_OSC_HZ;
    localparam int unsigned PWRUP_TIME_US   = 10;
    localparam int unsigned PWRUP_CYCLES    = (PWRUP_TIME_US * (CLOCK_HZ / 1_000_000));
    localparam int unsigned PWRUP_CNT_W     = 9;
    localparam int unsigned SLOW_DIV_W      = 10;
    localparam int unsigned TIMER_W         = 16;
    localparam int unsigned RX_CHANNELS     = 5;

endpackage : power_mode_pkg

// file: rtl/reset_and_power_mode_control.sv
module reset_and_power_mode_control #(
    parameter int unsigned RX_CHANNELS = power_mode_pkg::RX_CHANNELS,
    parameter int unsigned TIMER_W     = power_mode_pkg::TIMER_W
) (
    input  logic                          clock_i,
    input  logic                          rst_i,
    input  logic                          master_clear_pin_n_i,
    input  logic                          software_reset_request_i,
    input  logic                          brown_out_reset_source_i,
    input  logic                          watchdog_reset_source_i,
    input  power_mode_pkg::host_mode_req_t host_mode_req_i,
    input  logic                          host_bus_start_i,
    input  logic                          approach_detect_i,
    input  logic                          user_present_i,
    input  logic                          scan_done_i,
    input  logic [TIMER_W-1:0]            wake_period_i,
    input  logic [TIMER_W-1:0]            inactivity_period_i,
    input  logic [RX_CHANNELS-1:0]        scan_rx_mask_i,
    output logic                          system_reset_out_o,
    output power_mode_pkg::power_mode_t   mode_o,
    output logic                          scan_phase_o,
    output logic [RX_CHANNELS-1:0]        rx_enable_o,
    output power_mode_pkg::domain_ctrl_t  domain_ctrl_o
);
    if (RX_CHANNELS < 1 || RX_CHANNELS > 5) begin
        $error("reset_and_power_mode_control: RX_CHANNELS must be 1 to 5");
    end
    if (power_mode_pkg::PWRUP_CYCLES >= (1 << power_mode_pkg::PWRUP_CNT_W)) begin
        $error("reset_and_power_mode_control: power-up counter too narrow");
    end

    // ************************************************************
    // Reset merge and power-up hold
    // ************************************************************
    localparam logic [power_mode_pkg::PWRUP_CNT_W-1:0] PWRUP_LOAD =
        power_mode_pkg::PWRUP_CNT_W'(power_mode_pkg::PWRUP_CYCLES);

    logic [power_mode_pkg::PWRUP_CNT_W-1:0] pwrup_cnt_r;
    logic                                   sys_reset_r;
    power_mode_pkg::power_mode_t            mode_r;
    power_mode_pkg::power_mode_t            mode_nxt;
    logic                                   scan_r;

    // The watchdog is off and the processor halted in deep sleep, so
    // neither can pull the device out of it
    wire in_deep_w   = (mode_r == power_mode_pkg::MODE_DEEP_SLEEP);
    wire reset_src_w = !master_clear_pin_n_i                        // [RULE_01]
                     | (software_reset_request_i && !in_deep_w)     // [RULE_10]
                     | (watchdog_reset_source_i && !in_deep_w)
                     | brown_out_reset_source_i;
    // Brown-out keeps reloading the hold, so the hold ends only after its release
    wire sys_reset_nxt = reset_src_w || (pwrup_cnt_r > 1); // [RULE_02]

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            pwrup_cnt_r <= PWRUP_LOAD;
            sys_reset_r <= 1'b1;
        end else begin
            if (reset_src_w) begin
                pwrup_cnt_r <= PWRUP_LOAD; // [RULE_02]
            end else if (pwrup_cnt_r != '0) begin
                pwrup_cnt_r <= pwrup_cnt_r - 1'b1;
            end
            sys_reset_r <= sys_reset_nxt; // [RULE_01]
        end
    end

    // ************************************************************
    // Slow oscillator tick and timers
    // ************************************************************
    localparam logic [power_mode_pkg::SLOW_DIV_W-1:0] SLOW_LAST =
        power_mode_pkg::SLOW_DIV_W'(power_mode_pkg::SLOW_TICK_CYCLES - 1);

    logic [power_mode_pkg::SLOW_DIV_W-1:0] slow_div_r;
    logic                                  slow_tick_r;
    logic                                  wake_expire_w;
    logic                                  idle_expire_w;

    // The slow tick keeps running in every mode, deep sleep included
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            slow_div_r  <= '0;
            slow_tick_r <= 1'b0;
        end else begin
            slow_div_r  <= (slow_div_r == SLOW_LAST) ? '0 : slow_div_r + 1'b1; // [RULE_05]
            slow_tick_r <= (slow_div_r == SLOW_LAST);
        end
    end

    wire in_approach_w = (mode_r == power_mode_pkg::MODE_APPROACH);
    wire in_proc_w     = (mode_r == power_mode_pkg::MODE_PROCESSING);

    // Wake-up timer: sleeps between scans, period set by the host
    slow_tick_timer #(.WIDTH(TIMER_W)) u_wake_timer (
        .clock_i   (clock_i),
        .rst_i     (rst_i),
        .run_i     (in_approach_w && !scan_r && !sys_reset_r), // [RULE_09]
        .restart_i (1'b0),
        .tick_i    (slow_tick_r),
        .period_i  (wake_period_i), // [RULE_06]
        .expire_o  (wake_expire_w)
    );

    // Inactivity timer: any sign of a user starts the count over
    slow_tick_timer #(.WIDTH(TIMER_W)) u_idle_timer (
        .clock_i   (clock_i),
        .rst_i     (rst_i),
        .run_i     (in_proc_w && !sys_reset_r),
        .restart_i (user_present_i), // [RULE_16]
        .tick_i    (slow_tick_r),
        .period_i  (inactivity_period_i),
        .expire_o  (idle_expire_w)
    );

    // ************************************************************
    // Mode sequencing
    // ************************************************************
    wire req_w = host_mode_req_i.valid && (host_mode_req_i.mode != power_mode_pkg::MODE_PROCESSING
                 || !in_proc_w) && (host_mode_req_i.mode != 2'b11);

    always_comb begin
        mode_nxt = mode_r;
        if (sys_reset_r) begin
            mode_nxt = power_mode_pkg::MODE_PROCESSING; // [RULE_17]
        end else begin
            unique case (mode_r)
                power_mode_pkg::MODE_PROCESSING: begin
                    if (req_w) begin
                        mode_nxt = host_mode_req_i.mode; // [RULE_07]
                    end else if (idle_expire_w) begin
                        mode_nxt = power_mode_pkg::MODE_APPROACH; // [RULE_16]
                    end
                end
                power_mode_pkg::MODE_APPROACH: begin
                    if (req_w) begin
                        mode_nxt = host_mode_req_i.mode; // [RULE_08]
                    end else if (host_bus_start_i || (approach_detect_i && scan_r)) begin
                        mode_nxt = power_mode_pkg::MODE_PROCESSING; // [RULE_07]
                    end
                end
                power_mode_pkg::MODE_DEEP_SLEEP: begin
                    // No detection here: only the host can move the device on
                    if (req_w) begin
                        mode_nxt = host_mode_req_i.mode; // [RULE_11]
                    end else if (host_bus_start_i) begin
                        mode_nxt = power_mode_pkg::MODE_PROCESSING; // [RULE_14]
                    end
                end
                default: begin
                    mode_nxt = power_mode_pkg::MODE_PROCESSING;
                end
            endcase
        end
    end

    wire scan_nxt = (mode_nxt == power_mode_pkg::MODE_APPROACH) && !sys_reset_r &&
                    (wake_expire_w || (scan_r && !scan_done_i)); // [RULE_09]

    // ************************************************************
    // Domain and clock gating
    // ************************************************************
    wire nxt_proc_w  = (mode_nxt == power_mode_pkg::MODE_PROCESSING);
    wire nxt_deep_w  = (mode_nxt == power_mode_pkg::MODE_DEEP_SLEEP);
    wire active_w    = !sys_reset_nxt && (nxt_proc_w || scan_nxt);

    power_mode_pkg::domain_ctrl_t ctrl_nxt;
    assign ctrl_nxt.fast_osc_en          = !nxt_deep_w && (nxt_proc_w || scan_nxt
                                           || sys_reset_nxt); // [RULE_04]
    assign ctrl_nxt.slow_osc_en          = 1'b1; // [RULE_05]
    assign ctrl_nxt.signal_processor_run = active_w; // [RULE_03]
    assign ctrl_nxt.watchdog_en          = !sys_reset_nxt && !nxt_deep_w; // [RULE_10]
    assign ctrl_nxt.peripherals_active   = active_w; // [RULE_12]
    assign ctrl_nxt.all_domains_en       = !sys_reset_nxt && nxt_proc_w; // [RULE_12]
    assign ctrl_nxt.gesture_tracking_en  = !sys_reset_nxt && nxt_proc_w; // [RULE_13]
    assign ctrl_nxt.host_pins_active     = 1'b1; // [RULE_14]

    wire [RX_CHANNELS-1:0] rx_nxt = sys_reset_nxt ? '0 :
                                    nxt_proc_w    ? '1 :
                                    scan_nxt      ? scan_rx_mask_i : '0; // [RULE_08]

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            mode_r        <= power_mode_pkg::MODE_PROCESSING;
            scan_r        <= 1'b0;
            domain_ctrl_o <= '{fast_osc_en: 1'b1, slow_osc_en: 1'b1, host_pins_active: 1'b1,
                               default: 1'b0};
            rx_enable_o   <= '0;
        end else begin
            mode_r        <= mode_nxt;
            scan_r        <= scan_nxt;
            domain_ctrl_o <= ctrl_nxt;
            rx_enable_o   <= rx_nxt;
        end
    end

    assign system_reset_out_o = sys_reset_r;
    assign mode_o             = mode_r;
    assign scan_phase_o       = scan_r;

    // ************************************************************
    // Assertions
    // ************************************************************
    property p_master_clear_pin_resets;
        @(posedge clock_i) disable iff (rst_i)
        !master_clear_pin_n_i |=> system_reset_out_o;
    endproperty
    a_master_clear_pin_resets: assert property (p_master_clear_pin_resets) // [RULE_01]
        else $error("master clear did not raise system reset");

    property p_bor_extends;
        @(posedge clock_i) disable iff (rst_i)
        brown_out_reset_source_i ##1 !brown_out_reset_source_i |-> system_reset_out_o [*8];
    endproperty
    a_bor_extends: assert property (p_bor_extends) // [RULE_02]
        else $error("system reset released too soon after brown-out");

    property p_deep_fast_off;
        @(posedge clock_i) disable iff (rst_i)
        mode_o == power_mode_pkg::MODE_DEEP_SLEEP |-> !domain_ctrl_o.fast_osc_en
            && !domain_ctrl_o.watchdog_en && domain_ctrl_o.host_pins_active;
    endproperty
    a_deep_fast_off: assert property (p_deep_fast_off) // [RULE_04]
        else $error("deep sleep with fast oscillator or watchdog on");

    property p_slow_runs;
        @(posedge clock_i) disable iff (rst_i)
        $past(slow_tick_r) |-> !slow_tick_r && domain_ctrl_o.slow_osc_en;
    endproperty
    a_slow_runs: assert property (p_slow_runs) // [RULE_05]
        else $error("slow oscillator stopped or tick too long");

    property p_approach_wakes;
        @(posedge clock_i) disable iff (rst_i)
        in_approach_w && scan_r && approach_detect_i && !req_w && !sys_reset_r
            |=> mode_o == power_mode_pkg::MODE_PROCESSING;
    endproperty
    a_approach_wakes: assert property (p_approach_wakes) // [RULE_07]
        else $error("approach detection did not enter processing");

    property p_deep_stays;
        @(posedge clock_i) disable iff (rst_i)
        in_deep_w && !host_bus_start_i && !host_mode_req_i.valid && master_clear_pin_n_i
            && !brown_out_reset_source_i && !sys_reset_r |=> in_deep_w;
    endproperty
    a_deep_stays: assert property (p_deep_stays) // [RULE_10]
        else $error("deep sleep left without bus event or master clear");

    property p_processing_full;
        @(posedge clock_i) disable iff (rst_i)
        in_proc_w && !sys_reset_r |-> domain_ctrl_o.all_domains_en
            && domain_ctrl_o.signal_processor_run && domain_ctrl_o.peripherals_active;
    endproperty
    a_processing_full: assert property (p_processing_full) // [RULE_12]
        else $error("processing mode without all domains active");

    property p_gesture_only_proc;
        @(posedge clock_i) disable iff (rst_i)
        domain_ctrl_o.gesture_tracking_en |-> mode_o == power_mode_pkg::MODE_PROCESSING;
    endproperty
    a_gesture_only_proc: assert property (p_gesture_only_proc) // [RULE_13]
        else $error("gesture tracking outside processing mode");

    property p_scan_from_timer;
        @(posedge clock_i) disable iff (rst_i)
        $rose(scan_r) |-> $past(wake_expire_w);
    endproperty
    a_scan_from_timer: assert property (p_scan_from_timer) // [RULE_09]
        else $error("scan phase started without wake-up timer");

    property p_idle_to_approach;
        @(posedge clock_i) disable iff (rst_i)
        in_proc_w && idle_expire_w && !host_mode_req_i.valid && !sys_reset_r
            |=> mode_o == power_mode_pkg::MODE_APPROACH;
    endproperty
    a_idle_to_approach: assert property (p_idle_to_approach) // [RULE_16]
        else $error("inactivity timeout did not enter approach mode");

    property p_start_processing;
        @(posedge clock_i) disable iff (rst_i)
        $fell(system_reset_out_o) |-> mode_o == power_mode_pkg::MODE_PROCESSING
            && domain_ctrl_o.fast_osc_en && domain_ctrl_o.slow_osc_en;
    endproperty
    a_start_processing: assert property (p_start_processing) // [RULE_17]
        else $error("controller not in processing after reset release");

endmodule : reset_and_power_mode_control

// file: rtl/slow_tick_timer.sv
module slow_tick_timer #(
    parameter int unsigned WIDTH = 16
) (
    input  logic             clock_i,
    input  logic             rst_i,
    input  logic             run_i,
    input  logic             restart_i,
    input  logic             tick_i,
    input  logic [WIDTH-1:0] period_i,
    output logic             expire_o
);
    if (WIDTH < 2 || WIDTH > 31) begin
        $error("slow_tick_timer: WIDTH out of range");
    end

    logic [WIDTH-1:0] count_r;
    logic [WIDTH-1:0] count_nxt;
    wire  [WIDTH-1:0] last_w   = (period_i == '0) ? '0 : period_i - 1'b1;
    wire              at_end_w = tick_i && (count_r >= last_w);

    // A zero period behaves as one tick rather than never expiring
    assign count_nxt = (!run_i || restart_i) ? '0 :
                       at_end_w              ? '0 :
                       tick_i                ? count_r + 1'b1 : count_r;

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            count_r  <= '0;
            expire_o <= 1'b0;
        end else begin
            count_r  <= count_nxt;
            expire_o <= run_i && !restart_i && at_end_w; // [RULE_15]
        end
    end

endmodule : slow_tick_timer

// file: sim/host_side_model.sv
module host_side_model (
    input  wire logic                           clock_i,
    output logic                                master_clear_pin_n_o,
    output logic                                software_reset_request_o,
    output logic                                brown_out_reset_source_o,
    output logic                                watchdog_reset_source_o,
    output power_mode_pkg::host_mode_req_t      host_mode_req_o,
    output logic                                host_bus_start_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // ************************************************************
    // Idle levels
    // ************************************************************
    // Master clear idles high as its pull-up would hold it
    initial begin
        master_clear_pin_n_o     = 1'b1;
        software_reset_request_o = 1'b0;
        brown_out_reset_source_o = 1'b0;
        watchdog_reset_source_o  = 1'b0;
        host_mode_req_o          = '0;
        host_bus_start_o         = 1'b0;
    end

    // ************************************************************
    // Host messages, bus starts and reset source pulses
    // ************************************************************
    task automatic send_mode(input power_mode_pkg::power_mode_t mode);
        @(posedge clock_i);
        host_mode_req_o <= {1'b1, mode};
        @(posedge clock_i);
        host_mode_req_o <= '0;
    endtask : send_mode

    // Deep sleep is left on a bus start or host message, and on master clear or brown-out
    task automatic send_start();
        @(posedge clock_i);
        host_bus_start_o <= 1'b1;
        @(posedge clock_i);
        host_bus_start_o <= 1'b0;
    endtask : send_start

    // 0 master clear, 1 software, 2 brown-out, 3 watchdog
    task automatic pulse_source(input int which, input int len);
        @(posedge clock_i);
        case (which)
            0: master_clear_pin_n_o <= 1'b0;
            1: software_reset_request_o <= 1'b1;
            2: brown_out_reset_source_o <= 1'b1;
            default: watchdog_reset_source_o <= 1'b1;
        endcase
        repeat (len) @(posedge clock_i);
        master_clear_pin_n_o     <= 1'b1;
        software_reset_request_o <= 1'b0;
        brown_out_reset_source_o <= 1'b0;
        watchdog_reset_source_o  <= 1'b0;
    endtask : pulse_source
endmodule : host_side_model

// file: sim/test_reset_and_power_mode_control.sv
module test_reset_and_power_mode_control;
    timeunit 1ns;
    timeprecision 1ps;

    logic clock_i, rst_i, approach_i, user_i, scan_done_i;
    logic [15:0] wake_per, inact_per;
    logic [4:0]  mask;
    wire logic master_clear_pin_n, software_reset_request, bor, wdt, start, system_reset_out, scan;
    wire logic [4:0] rx;
    wire power_mode_pkg::host_mode_req_t req;
    wire power_mode_pkg::power_mode_t    mode;
    wire power_mode_pkg::domain_ctrl_t   dom;
    int error_cnt;
    int tests_run;
    int n;

    always #20 clock_i = ~clock_i;

    host_side_model u_host (.clock_i(clock_i), .master_clear_pin_n_o(master_clear_pin_n),
        .software_reset_request_o(software_reset_request), .brown_out_reset_source_o(bor),
        .watchdog_reset_source_o(wdt), .host_mode_req_o(req), .host_bus_start_o(start));

    reset_and_power_mode_control u_dut (.clock_i(clock_i), .rst_i(rst_i),
        .master_clear_pin_n_i(master_clear_pin_n), .software_reset_request_i(software_reset_request),
        .brown_out_reset_source_i(bor), .watchdog_reset_source_i(wdt),
        .host_mode_req_i(req), .host_bus_start_i(start), .approach_detect_i(approach_i),
        .user_present_i(user_i), .scan_done_i(scan_done_i), .wake_period_i(wake_per),
        .inactivity_period_i(inact_per), .scan_rx_mask_i(mask), .system_reset_out_o(system_reset_out),
        .mode_o(mode), .scan_phase_o(scan), .rx_enable_o(rx), .domain_ctrl_o(dom));

    // ************************************************************
    // Compare and wait helpers
    // ************************************************************
    task automatic chk_bit(input string what, input logic exp, input logic got);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %0h seen %0h", what, exp, got);
        end
    endtask : chk_bit

    task automatic chk_mode(input string what, input power_mode_pkg::power_mode_t exp,
                            input power_mode_pkg::power_mode_t got);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %0h seen %0h", what, exp, got);
        end
    endtask : chk_mode

    task automatic chk_vec(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %0h seen %0h", what, exp, got);
        end
    endtask : chk_vec

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up

    // Waits for 0 reset low, 1 scan phase, 2 approach mode; a timeout ends the run
    task automatic wait_for(input int sel, input int lim, output int cnt);
        logic hit;
        cnt = 0;
        hit = 1'b0;
        while (!hit) begin
            @(posedge clock_i);
            #1;
            cnt++;
            case (sel)
                0: hit = (system_reset_out === 1'b0);
                1: hit = (scan === 1'b1);
                default: hit = (mode === power_mode_pkg::MODE_APPROACH);
            endcase
            if (!hit && cnt >= lim) begin
                error_cnt++;
                $display("unexpected wait %0d: expected event seen timeout", sel);
                wrap_up();
            end
        end
    endtask : wait_for

    // 0 approach, 1 user present, 2 scan done
    task automatic pulse(input int sel);
        @(posedge clock_i);
        approach_i  <= (sel == 0);
        user_i      <= (sel == 1);
        scan_done_i <= (sel == 2);
        @(posedge clock_i);
        approach_i  <= 1'b0;
        user_i      <= 1'b0;
        scan_done_i <= 1'b0;
        #1;
    endtask : pulse

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_reset_release();
        wait_for(0, 400, n);
        chk_mode("mode", power_mode_pkg::MODE_PROCESSING, mode);
        chk_vec("domains", 8'hff, dom);
        chk_bit("gesture", 1'b1, dom.gesture_tracking_en);
        chk_vec("rx", 8'h1f, {3'h0, rx});
        $display("done: reset_release");
    endtask : t_reset_release

    // Each source is raised from approach mode and must bring processing back
    task automatic t_sources();
        for (int i = 0; i < 4; i++) begin
            u_host.send_mode(power_mode_pkg::MODE_APPROACH);
            #1;
            chk_mode("mode", power_mode_pkg::MODE_APPROACH, mode);
            u_host.pulse_source(i, 1);
            #1;
            chk_bit("system_reset_out", 1'b1, system_reset_out);
            repeat (200) @(posedge clock_i);
            #1;
            chk_bit("system_reset_out held", 1'b1, system_reset_out);
            wait_for(0, 100, n);
            chk_mode("mode", power_mode_pkg::MODE_PROCESSING, mode);
        end
        $display("done: sources");
    endtask : t_sources

    task automatic t_brown_out();
        u_host.pulse_source(2, 400);
        #1;
        chk_bit("system_reset_out", 1'b1, system_reset_out);
        wait_for(0, 300, n);
        chk_bit("power-up restarted", 1'b1, n > 240);
        $display("done: brown_out");
    endtask : t_brown_out

    task automatic t_deep_sleep();
        u_host.send_mode(power_mode_pkg::MODE_DEEP_SLEEP);
        #1;
        chk_mode("mode", power_mode_pkg::MODE_DEEP_SLEEP, mode);
        chk_bit("fast osc", 1'b0, dom.fast_osc_en);
        chk_bit("slow osc", 1'b1, dom.slow_osc_en);
        chk_bit("processor", 1'b0, dom.signal_processor_run);
        chk_bit("watchdog", 1'b0, dom.watchdog_en);
        chk_bit("gesture", 1'b0, dom.gesture_tracking_en);
        chk_bit("host pins", 1'b1, dom.host_pins_active);
        for (int i = 1; i < 4; i += 2) begin
            u_host.pulse_source(i, 1);
            #1;
            chk_bit("system_reset_out", 1'b0, system_reset_out);
        end
        pulse(0);
        chk_mode("mode", power_mode_pkg::MODE_DEEP_SLEEP, mode);
        u_host.send_start();
        #1;
        chk_mode("mode", power_mode_pkg::MODE_PROCESSING, mode);
        chk_vec("domains", 8'hff, dom);
        u_host.send_mode(power_mode_pkg::MODE_DEEP_SLEEP);
        u_host.pulse_source(0, 1);
        wait_for(0, 300, n);
        chk_mode("mode", power_mode_pkg::MODE_PROCESSING, mode);
        $display("done: deep_sleep");
    endtask : t_deep_sleep

    task automatic t_approach();
        u_host.send_mode(power_mode_pkg::power_mode_t'(2'b11));
        #1;
        chk_mode("mode", power_mode_pkg::MODE_PROCESSING, mode);
        @(posedge clock_i);
        wake_per <= 16'h0002;
        mask     <= 5'h06;
        u_host.send_mode(power_mode_pkg::MODE_APPROACH);
        #1;
        chk_bit("fast osc", 1'b0, dom.fast_osc_en);
        chk_vec("rx", 8'h00, {3'h0, rx});
        pulse(0);
        chk_mode("mode", power_mode_pkg::MODE_APPROACH, mode);
        wait_for(1, 2400, n);
        chk_bit("wake delay", 1'b1, n >= 780);
        chk_vec("rx", 8'h06, {3'h0, rx});
        chk_bit("fast osc", 1'b1, dom.fast_osc_en);
        pulse(2);
        chk_bit("scan", 1'b0, scan);
        wait_for(1, 2400, n);
        chk_bit("wake delay", 1'b1, n >= 780);
        pulse(0);
        chk_mode("mode", power_mode_pkg::MODE_PROCESSING, mode);
        chk_vec("rx", 8'h1f, {3'h0, rx});
        $display("done: approach");
    endtask : t_approach

    task automatic t_inactivity();
        @(posedge clock_i);
        inact_per <= 16'h0002;
        for (int i = 0; i < 6; i++) begin
            pulse(1);
            repeat (500) @(posedge clock_i);
            #1;
            chk_mode("mode", power_mode_pkg::MODE_PROCESSING, mode);
        end
        wait_for(2, 2400, n);
        chk_bit("timeout delay", 1'b1, n >= 280);
        u_host.send_mode(power_mode_pkg::MODE_PROCESSING);
        #1;
        chk_mode("mode", power_mode_pkg::MODE_PROCESSING, mode);
        @(posedge clock_i);
        inact_per <= 16'hffff;
        $display("done: inactivity");
    endtask : t_inactivity

    // ************************************************************
    // Main sequence
    // ************************************************************
    // A long inactivity period keeps the timeout out of the other scenarios
    initial begin
        clock_i     = 1'b0;
        rst_i       = 1'b1;
        approach_i  = 1'b0;
        user_i      = 1'b0;
        scan_done_i = 1'b0;
        wake_per    = 16'h0002;
        inact_per   = 16'hffff;
        mask        = 5'h01;
        error_cnt   = 0;
        tests_run   = 0;
        repeat (6) @(posedge clock_i);
        rst_i <= 1'b0;
        t_reset_release();
        t_sources();
        t_brown_out();
        t_deep_sleep();
        t_approach();
        t_inactivity();
        wrap_up();
    end
endmodule : test_reset_and_power_mode_control
